// File: dv/testbench.sv
/*
 Self-checking bench for the touch key scan counters.
 Assumes the register map and one-wait-state bus of the top module.
*/
`timescale 1ns/1ps
module testbench;
    import tks_pkg::*;
    logic clk_i = 0;
    logic rst_n_i = 0;
    tks_addr_t avs_address_i = '0;
    logic avs_read_i = 0;
    logic avs_write_i = 0;
    logic [31:0] avs_writedata_i = '0;
    logic [3:0] avs_byteenable_i = 4'hF;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic [NMOD-1:0] key_osc_i, ref_osc_i, key_osc_en_o, ref_osc_en_o;
    logic [1:0] osc_freq_sel_o;
    tks_cap_t [NMOD-1:0] ref_cap_code_o;
    logic irq_o;
    int failures = 0;
    int checked = 0;
    int seed = 28320;
    tks_cap_t scan_mem [NMOD][8];
    logic [31:0] rd;
    int run_len;

    always #2 clk_i = ~clk_i;

    tks_top dut (.clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
        .key_osc_i, .ref_osc_i, .key_osc_en_o, .ref_osc_en_o, .osc_freq_sel_o,
        .ref_cap_code_o, .irq_o);
    tks_osc_model #(.NM(NMOD)) osc (.clk_i, .key_en_i(key_osc_en_o),
        .ref_en_i(ref_osc_en_o), .key_osc_o(key_osc_i), .ref_osc_o(ref_osc_i));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic chk_rng(input string what, input int lo, input int hi,
                           input logic [31:0] got);
        checked++;
        if ($isunknown(got) || got < lo || got > hi)
        begin
            failures++;
            $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : chk_rng

    // request held until the rising edge that samples waitrequest low
    task automatic bus(input logic wr, input tks_addr_t a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (avs_waitrequest_o !== 1'b0 && n < 20);
        rd = avs_readdata_o;
        avs_write_i <= 0;
        avs_read_i <= 0;
        if (n >= 20)
        begin
            failures++;
            stop_test();
        end
    endtask : bus

    task automatic rd_chk(input string what, input tks_addr_t a, input logic [31:0] exp);
        bus(0, a, 0);
        chk(what, exp, rd);
    endtask : rd_chk

    task automatic get16(input tks_addr_t lo, input tks_addr_t hi, output logic [15:0] v);
        bus(0, lo, 0);
        v[7:0] = rd[7:0];
        bus(0, hi, 0);
        v[15:8] = rd[7:0];
    endtask : get16

    function automatic tks_addr_t ma(input int m, input int sub);
        return tks_addr_t'(8'h40 + 16 * m + 4 * sub);
    endfunction : ma

    task automatic measure(input logic [7:0] ctrl, input bit scan);
        int n;
        n = 0;
        bus(1, A_CTRL, {24'h0, ctrl});
        while (key_osc_en_o[0] !== 1'b1 && n < 8)
        begin
            @(negedge clk_i);
            n++;
        end
        chk("osc run", 8'hFF, {key_osc_en_o, ref_osc_en_o});
        run_len = 0;
        while (key_osc_en_o[0] === 1'b1 && run_len < 90000)
        begin
            @(negedge clk_i);
            run_len++;
            if (scan && run_len == 320)
                for (int m = 0; m < NMOD; m++)
                    chk("scan code", scan_mem[m][2], ref_cap_code_o[m]);
        end
        chk("osc stop", 0, {key_osc_en_o, ref_osc_en_o});
    endtask : measure

    initial
    begin
        logic [15:0] v;
        int exp;
        logic [7:0] pre;
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1;
        rd_chk("ctrl reset", A_CTRL, 0);
        rd_chk("freq reset", A_FREQ, 3);
        chk("freq pin reset", 3, osc_freq_sel_o);
        rd_chk("unmapped", 8'h3C, 0);
        bus(1, A_CTRL, 32'h58);
        rd_chk("flag write one", A_CTRL, 0);
        for (int f = 0; f < 4; f++)
        begin
            bus(1, A_FREQ, 32'hFC | f);
            rd_chk("freq", A_FREQ, f);
            chk("freq pin", f, osc_freq_sel_o);
        end
        $display("test config done");
        for (int m = 0; m < NMOD; m++)
            for (int e = 0; e < 8; e++)
            begin
                scan_mem[m][e] = tks_cap_t'($random(seed));
                bus(1, A_SCAN_WR, {17'h0, 2'(m), 3'(e), scan_mem[m][e]});
            end
        // module 0 on fsys/4, the others on the slow reference pad
        bus(1, A_MOD_CTRL, 32'h11);
        for (int s = 0; s < 4; s++)
        begin
            pre = 8'hF8 + 8'($random(seed) & 3);
            bus(1, A_PRELOAD, {24'h0, pre});
            measure(8'(8'h24 | s), 1);
            exp = (256 - pre) * 128;
            chk_rng("slot length", exp - 8, exp + 8, run_len);
            rd_chk("ctrl after ovf", A_CTRL, 32'h64 | s);
            rd_chk("irq status", A_IRQ_ST, 1);
            get16(A_CAL_LO, A_CAL_HI, v);
            chk_rng("calib count", (run_len >> s) - 3, (run_len >> s) + 3, v);
            repeat (20) @(posedge clk_i);
            bus(0, A_CAL_LO, 0);
            chk("calib frozen", v[7:0], rd);
            for (int m = 0; m < NMOD; m++)
            begin
                get16(ma(m, SUB_CF_LO), ma(m, SUB_CF_HI), v);
                exp = run_len / (6 + 2 * m);
                chk_rng("cf count", exp - 3, exp + 3, v);
            end
            bus(1, A_CTRL, 32'h58 | s);
            rd_chk("ctrl stopped", A_CTRL, 32'h40 | s);
            rd_chk("calib cleared", A_CAL_LO, 0);
            rd_chk("cf cleared", ma(0, SUB_CF_HI), 0);
            bus(1, A_CTRL, 32'h0);
            rd_chk("ovf cleared", A_CTRL, 0);
            bus(1, A_IRQ_ST, 32'h7);
        end
        $display("test short runs done");
        bus(1, A_MOD_CTRL, 32'hE);
        bus(1, A_PRELOAD, 0);
        bus(1, A_IRQ_MASK, 1);
        measure(8'h20, 0);
        exp = 256 * 32 * 10;
        chk_rng("all slots", exp - 40, exp + 40, run_len);
        rd_chk("calib wrap flag", A_CTRL, 32'h68);
        get16(A_CAL_LO, A_CAL_HI, v);
        chk_rng("calib wrapped", run_len - 65539, run_len - 65533, v);
        get16(ma(1, SUB_CF_LO), ma(1, SUB_CF_HI), v);
        chk_rng("own slot cf", 4092, 4100, v);
        @(negedge clk_i);
        chk("irq raised", 1, irq_o);
        bus(1, A_IRQ_MASK, 0);
        @(negedge clk_i);
        chk("irq masked", 0, irq_o);
        bus(1, A_IRQ_MASK, 1);
        @(negedge clk_i);
        chk("irq unmasked", 1, irq_o);
        bus(1, A_IRQ_ST, 1);
        @(negedge clk_i);
        chk("irq cleared", 0, irq_o);
        $display("test long run done");
        bus(1, A_MOD_CTRL, 0);
        for (int m = 0; m < NMOD; m++)
        begin
            exp = $random(seed) & 32'h3FF;
            bus(1, ma(m, SUB_CAP_LO), exp & 32'hFF);
            bus(1, ma(m, SUB_CAP_HI), 32'hFC | (exp >> 8));
            rd_chk("cap high", ma(m, SUB_CAP_HI), exp >> 8);
            chk("cap code pin", exp, ref_cap_code_o[m]);
        end
        $display("test cap codes done");
        stop_test();
    end

    initial
    begin
        #400000;
        failures++;
        stop_test();
    end
endmodule : testbench

// File: dv/tks_osc_model.sv
/*
 Pad oscillator model: one key and one reference oscillator per module.
 Assumes enables come from the block on clk_i; a stopped pad stays low.
*/
`timescale 1ns/1ps
module tks_osc_model
#(
    parameter int NM = 4,
    parameter int REF_HALF = 5
)
(
    input wire logic clk_i,
    input wire logic [NM-1:0] key_en_i,
    input wire logic [NM-1:0] ref_en_i,
    output logic [NM-1:0] key_osc_o = '0,
    output logic [NM-1:0] ref_osc_o = '0
);
    int kc[NM];
    int rc[NM];

    // key period differs per module so a swapped count shows up
    always @(posedge clk_i)
    begin
        for (int m = 0; m < NM; m++)
        begin
            kc[m] <= key_en_i[m] ? (kc[m] + 1) % (6 + 2 * m) : 0;
            rc[m] <= ref_en_i[m] ? (rc[m] + 1) % (2 * REF_HALF) : 0;
            key_osc_o[m] <= key_en_i[m] && kc[m] >= 3 + m;
            ref_osc_o[m] <= ref_en_i[m] && rc[m] >= REF_HALF;
        end
    end
endmodule : tks_osc_model

// File: pkg/tks_cnt_if.sv
/*
 Link between the scan controller and one touch key module counter set.
 Assumes all signals are on clk_i.
*/
`timescale 1ns/1ps
interface tks_cnt_if;
    import tks_pkg::*;
    logic run;
    logic clear;
    logic share;
    logic start_pulse;
    logic key_tick;
    logic slot_tick;
    logic [7:0] preload;
    tks_cnt_t cf_count;
    logic cf_wrap;
    logic slot_end;
    logic slot_done;
    modport ctl (output run, clear, share, start_pulse, key_tick, slot_tick, preload,
                 input cf_count, cf_wrap, slot_end, slot_done);
    modport cnt (input run, clear, share, start_pulse, key_tick, slot_tick, preload,
                 output cf_count, cf_wrap, slot_end, slot_done);
endinterface : tks_cnt_if

// File: pkg/tks_pkg.sv
/*
 Shared constants and types for the touch key scan counters.
 Assumes a 32-bit Avalon-MM slave with byte addresses, one word per register.
*/
package tks_pkg;
    localparam int NMOD = 4;
    localparam int CNT_W = 16;
    localparam int CAP_W = 10;
    localparam int SCAN_DEPTH = 8;
    typedef logic [CNT_W-1:0] tks_cnt_t;
    typedef logic [CAP_W-1:0] tks_cap_t;
    typedef logic [7:0] tks_addr_t;
    localparam tks_cnt_t CNT_MAX = 16'hFFFF;
    localparam logic [4:0] PRE_MAX = 5'h1F;
    localparam logic [7:0] TMR_MAX = 8'hFF;
    localparam logic [1:0] SLOT_DIV_TAP = 2'h3;
    localparam logic [1:0] FREQ_RST = 2'h3;
    // register byte addresses
    localparam tks_addr_t A_PRELOAD = 8'h00;
    localparam tks_addr_t A_CTRL = 8'h04;
    localparam tks_addr_t A_FREQ = 8'h08;
    localparam tks_addr_t A_CAL_LO = 8'h0C;
    localparam tks_addr_t A_CAL_HI = 8'h10;
    localparam tks_addr_t A_IRQ_ST = 8'h14;
    localparam tks_addr_t A_IRQ_MASK = 8'h18;
    localparam tks_addr_t A_MOD_CTRL = 8'h1C;
    localparam tks_addr_t A_SCAN_WR = 8'h20;
    localparam logic [1:0] MOD_SEL = 2'h1;
    localparam logic [1:0] SUB_CF_LO = 2'h0;
    localparam logic [1:0] SUB_CF_HI = 2'h1;
    localparam logic [1:0] SUB_CAP_LO = 2'h2;
    localparam logic [1:0] SUB_CAP_HI = 2'h3;
    // register bit positions
    localparam int CS_SLOT_OVF = 6;
    localparam int CS_START = 5;
    localparam int CS_CF_OVF = 4;
    localparam int CS_CAL_OVF = 3;
    localparam int CS_SHARE = 2;
    localparam int MC_AUTO = 4;
    localparam int SW_ENTRY_LSB = 10;
    localparam int SW_MOD_LSB = 13;
    localparam int IRQ_SLOT = 0;
    localparam int IRQ_CF = 1;
    localparam int IRQ_CAL = 2;

    // divided system clock tick: 2^sel cycles per tick
    function automatic logic cal_tick(input logic [1:0] sel, input logic [2:0] div);
        logic [2:0] mask;
        mask = 3'((4'h1 << sel) - 4'h1);
        return (div & mask) == mask;
    endfunction : cal_tick
endpackage : tks_pkg

// File: rtl/tks_module.sv
/*
 One touch key module: C/F counter, 5-bit slot prescaler, 8-bit slot timer.
 Assumes tick inputs are single-cycle pulses on clk_i.
*/
`timescale 1ns/1ps
module tks_module
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    tks_cnt_if.cnt c
);
    import tks_pkg::*;
    typedef struct packed {
        tks_cnt_t cf;
        logic [4:0] pre;
        logic [7:0] tmr;
        logic done;
    } tks_mod_s;
    tks_mod_s r;
    tks_mod_s n;
    logic cnt_en;

    // unshared: a module stops on its own window
    assign cnt_en = c.run & ~(r.done & ~c.share); // R2 R13

    always_comb
    begin
        n = r;
        if (c.start_pulse)
        begin
            n = '0; // R6
            n.tmr = c.preload;
        end
        else if (c.clear) // R5
        begin
            n.cf = '0; // R4
            n.pre = '0;
            n.done = 1'b0;
        end
        else if (cnt_en)
        begin
            if (c.key_tick)
            begin
                n.cf = r.cf + 16'h0001; // R19
            end
            if (c.slot_tick)
            begin
                n.pre = r.pre + 5'h01;
                if (r.pre == PRE_MAX)
                begin
                    n.tmr = r.tmr + 8'h01; // R17
                    n.done = (r.tmr == TMR_MAX);
                end
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            r <= '0;
        end
        else
        begin
            r <= n;
        end
    end

    assign c.cf_count = r.cf;
    assign c.slot_done = r.done;
    assign c.cf_wrap = cnt_en & ~c.start_pulse & ~c.clear & c.key_tick & (r.cf == CNT_MAX);
    assign c.slot_end = cnt_en & ~c.start_pulse & ~c.clear & c.slot_tick & (r.pre == PRE_MAX);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_timer_kept: assert property (c.clear && !c.start_pulse |=> $stable(r.tmr)) // R5
        else $error("slot timer changed while detection stopped");
    a_cf_frozen: assert property (!c.run && !c.clear && !c.start_pulse |=> $stable(r.cf)) // R13
        else $error("cf counter moved while stopped");
    a_slot_done: assert property ($rose(r.done) |-> $past(r.tmr) == TMR_MAX && r.pre == 5'h00) // R17
        else $error("slot window ended early");
endmodule : tks_module

// File: rtl/tks_sync.sv
/*
 Three-stage synchroniser with rising-edge pulse for an oscillator pin.
 Assumes the pin toggles slower than a third of clk_i.
*/
`timescale 1ns/1ps
module tks_sync
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic async_i,
    output logic rise_o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } tks_sync_s;
    tks_sync_s r;
    tks_sync_s n;

    always_comb
    begin
        n = r;
        n.s1 = async_i;
        n.s2 = r.s1;
        n.s3 = r.s2;
        // change accepted only once stages two and three agree
        if (r.s2 == r.s3)
        begin
            n.level = r.s3;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            r <= '0;
        end
        else
        begin
            r <= n;
        end
    end

    assign rise_o = (r.s2 == r.s3) & r.s3 & ~r.level;
endmodule : tks_sync

// File: rtl/tks_top.sv
/*
 Touch key scan counters: control, status, result registers on Avalon-MM,
 per-module counters, calibration counter, slot overflow and interrupt.
 Assumes oscillator outputs arrive asynchronously and toggle below 40 MHz.
*/
// Chosen here: the placing of the registers and the Avalon-MM register port.
// Operation
// R1 - selected slot counter overflow sets slot overflow flag and touch interrupt flag
// R2 - slot overflow stops oscillators and all counters and the slot timer
// R3 - writing one to slot overflow flag does nothing; writing zero clears it
// R4 - detect start low holds C/F, calibration and prescaler counters at zero
// R5 - detect start low leaves the 8-bit slot timer untouched
// R6 - detect start rising starts counters, slot timer and oscillators
// R7 - any C/F counter wrap sets a sticky flag cleared by writing zero
// R8 - calibration counter wrap sets a sticky flag cleared by writing zero
// R9 - share select picks module 0 counter or every module's own counter
// R10 - calibration clock is system clock divided by 1, 2, 4 or 8
// R11 - two-bit oscillator frequency select, reset to three
// R12 - calibration counter stops and holds its value on slot overflow
// R13 - C/F counters stop and hold their values on slot overflow
// R14 - auto scan loads next slot reference capacitor code at each slot end
// R15 - reference capacitance is code times 50 pF over 1024
// R16 - unimplemented bits read as zero
// R17 - slot overflow after 256 minus preload units of 32 slot clocks
// R18 - per-module slot clock is module 0 reference oscillator or system clock over 4
// R19 - 16-bit result counters wrap to zero and flag the wrap
`timescale 1ns/1ps
module tks_top
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire tks_pkg::tks_addr_t avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [tks_pkg::NMOD-1:0] key_osc_i,
    input wire logic [tks_pkg::NMOD-1:0] ref_osc_i,
    output logic [tks_pkg::NMOD-1:0] key_osc_en_o,
    output logic [tks_pkg::NMOD-1:0] ref_osc_en_o,
    output logic [1:0] osc_freq_sel_o,
    output tks_pkg::tks_cap_t [tks_pkg::NMOD-1:0] ref_cap_code_o,
    output logic irq_o
);
    import tks_pkg::*;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [7:0] preload;
        logic start;
        logic slot_ovf;
        logic cf_ovf;
        logic cal_ovf;
        logic share;
        logic [1:0] cal_sel;
        logic [1:0] freq;
        tks_cnt_t calib;
        logic run;
        logic [2:0] div;
        logic [2:0] irq_st;
        logic [2:0] irq_mask;
        logic irq;
        logic [NMOD-1:0] tss;
        logic auto_scan;
        logic [2:0] scan_ptr;
        logic [NMOD-1:0][CAP_W-1:0] cap;
        logic [NMOD-1:0][SCAN_DEPTH-1:0][CAP_W-1:0] mem;
    } tks_top_s;

    tks_top_s r;
    tks_top_s n;
    tks_cnt_if cif[NMOD]();
    logic [NMOD-1:0] key_rise;
    logic [NMOD-1:0] ref_rise;
    logic [NMOD-1:0] done;
    logic [NMOD-1:0] wrap;
    logic [NMOD-1:0] slot_end;
    tks_cnt_t cf_cnt [NMOD];
    logic req;
    logic wr_en;
    logic start_rise;
    logic ovf_evt;
    logic cal_tk;
    logic fsys4_tk;
    logic [2:0] ptr_nxt;
    logic [31:0] rd_mux;
    logic ctrl_wr;

    function automatic logic mod_hit(input tks_addr_t a);
        return a[7:6] == MOD_SEL;
    endfunction : mod_hit

    genvar g;
    generate
        for (g = 0; g < NMOD; g++)
        begin : g_mod
            tks_sync u_key (.clk_i(clk_i), .rst_n_i(rst_n_i), .async_i(key_osc_i[g]),
                            .rise_o(key_rise[g]));
            tks_sync u_ref (.clk_i(clk_i), .rst_n_i(rst_n_i), .async_i(ref_osc_i[g]),
                            .rise_o(ref_rise[g]));
            tks_module u_cnt (.clk_i(clk_i), .rst_n_i(rst_n_i), .c(cif[g]));
            assign cif[g].run = r.run;
            assign cif[g].clear = ~r.start; // R4
            assign cif[g].share = r.share;
            assign cif[g].start_pulse = start_rise;
            assign cif[g].key_tick = key_rise[g];
            assign cif[g].slot_tick = r.tss[g] ? fsys4_tk : ref_rise[0]; // R18
            assign cif[g].preload = r.preload;
            assign done[g] = cif[g].slot_done;
            assign wrap[g] = cif[g].cf_wrap;
            assign slot_end[g] = cif[g].slot_end;
            assign cf_cnt[g] = cif[g].cf_count;
        end
    endgenerate

    assign req = avs_read_i | avs_write_i;
    // one wait cycle per access; writes land on the edge that samples waitrequest low
    assign wr_en = avs_write_i & r.ack & avs_byteenable_i[0];
    assign start_rise = wr_en & (avs_address_i == A_CTRL)
                        & avs_writedata_i[CS_START] & ~r.start; // R6
    assign ovf_evt = r.run & (r.share ? done[0] : &done); // R9
    assign cal_tk = cal_tick(r.cal_sel, r.div); // R10
    assign fsys4_tk = (r.div[1:0] == SLOT_DIV_TAP);
    assign ptr_nxt = r.scan_ptr + 3'h1;
    // software write to the control/status register
    assign ctrl_wr = wr_en & (avs_address_i == A_CTRL);

    always_comb
    begin
        rd_mux = '0; // R16
        case (avs_address_i)
            A_PRELOAD: rd_mux[7:0] = r.preload;
            A_CTRL: rd_mux[6:0] = {r.slot_ovf, r.start, r.cf_ovf, r.cal_ovf, r.share,
                                   r.cal_sel};
            A_FREQ: rd_mux[1:0] = r.freq;
            A_CAL_LO: rd_mux[7:0] = r.calib[7:0];
            A_CAL_HI: rd_mux[7:0] = r.calib[15:8];
            A_IRQ_ST: rd_mux[2:0] = r.irq_st;
            A_IRQ_MASK: rd_mux[2:0] = r.irq_mask;
            A_MOD_CTRL: rd_mux[4:0] = {r.auto_scan, r.tss};
            default:
            begin
                if (mod_hit(avs_address_i))
                begin
                    case (avs_address_i[3:2])
                        SUB_CF_LO: rd_mux[7:0] = cf_cnt[avs_address_i[5:4]][7:0];
                        SUB_CF_HI: rd_mux[7:0] = cf_cnt[avs_address_i[5:4]][15:8];
                        SUB_CAP_LO: rd_mux[7:0] = r.cap[avs_address_i[5:4]][7:0];
                        SUB_CAP_HI: rd_mux[1:0] = r.cap[avs_address_i[5:4]][9:8];
                    endcase
                end
            end
        endcase
    end

    always_comb
    begin
        n = r;
        n.ack = req & ~r.ack;
        if (req & ~r.ack)
        begin
            n.rdata = rd_mux;
        end
        n.div = r.div + 3'h1;
        if (wr_en)
        begin
            case (avs_address_i)
                A_PRELOAD: n.preload = avs_writedata_i[7:0];
                A_CTRL:
                begin
                    n.start = avs_writedata_i[CS_START];
                    n.share = avs_writedata_i[CS_SHARE];
                    n.cal_sel = avs_writedata_i[1:0];
                    n.slot_ovf = r.slot_ovf & avs_writedata_i[CS_SLOT_OVF]; // R3
                    n.cf_ovf = r.cf_ovf & avs_writedata_i[CS_CF_OVF]; // R7
                    n.cal_ovf = r.cal_ovf & avs_writedata_i[CS_CAL_OVF]; // R8
                end
                A_FREQ: n.freq = avs_writedata_i[1:0]; // R11
                A_IRQ_ST: n.irq_st = r.irq_st & ~avs_writedata_i[2:0];
                A_IRQ_MASK: n.irq_mask = avs_writedata_i[2:0];
                A_MOD_CTRL:
                begin
                    n.tss = avs_writedata_i[NMOD-1:0];
                    n.auto_scan = avs_writedata_i[MC_AUTO];
                end
                A_SCAN_WR: n.mem[avs_writedata_i[SW_MOD_LSB+:2]][avs_writedata_i[SW_ENTRY_LSB+:3]]
                               = avs_writedata_i[CAP_W-1:0];
                default:
                begin
                    if (mod_hit(avs_address_i) && avs_address_i[3:2] == SUB_CAP_LO)
                    begin
                        n.cap[avs_address_i[5:4]][7:0] = avs_writedata_i[7:0];
                    end
                    if (mod_hit(avs_address_i) && avs_address_i[3:2] == SUB_CAP_HI)
                    begin
                        n.cap[avs_address_i[5:4]][9:8] = avs_writedata_i[1:0];
                    end
                end
            endcase
        end
        if (start_rise)
        begin
            n.run = 1'b1; // R6
            n.scan_ptr = '0;
        end
        // calibration counter: cleared while stopped, frozen after overflow
        if (!r.start)
        begin
            n.calib = '0; // R4
        end
        else if (r.run && cal_tk)
        begin
            n.calib = r.calib + 16'h0001; // R12 R19
            if (r.calib == CNT_MAX)
            begin
                n.cal_ovf = 1'b1; // R8
                n.irq_st[IRQ_CAL] = 1'b1;
            end
        end
        if (|wrap)
        begin
            n.cf_ovf = 1'b1; // R7
            n.irq_st[IRQ_CF] = 1'b1;
        end
        if (ovf_evt)
        begin
            n.run = 1'b0; // R2
            n.slot_ovf = 1'b1; // R1
            n.irq_st[IRQ_SLOT] = 1'b1;
        end
        if (!n.start)
        begin
            n.run = 1'b0;
        end
        // module 0 paces the scan table; hardware load beats a same-cycle write
        if (r.auto_scan && slot_end[0])
        begin
            n.scan_ptr = ptr_nxt;
            for (int m = 0; m < NMOD; m++)
            begin
                n.cap[m] = r.mem[m][ptr_nxt]; // R14
            end
        end
        n.irq = |(n.irq_st & n.irq_mask);
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            r <= '0;
            r.freq <= FREQ_RST; // R11
        end
        else
        begin
            r <= n;
        end
    end

    assign avs_waitrequest_o = req & ~r.ack;
    assign avs_readdata_o = r.rdata;
    assign key_osc_en_o = {NMOD{r.run}}; // R2
    assign ref_osc_en_o = {NMOD{r.run}};
    assign osc_freq_sel_o = r.freq;
    // capacitance is linear in the code, so the code goes out unscaled
    assign ref_cap_code_o = r.cap; // R15
    assign irq_o = r.irq;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_start_taken;
        start_rise && !ovf_evt;
    endsequence
    sequence s_running;
        r.run && r.start;
    endsequence
    sequence s_overflow;
        ovf_evt ##1 (r.slot_ovf && r.irq_st[IRQ_SLOT]);
    endsequence

    a_slot_flag_set: assert property (ovf_evt |-> s_overflow) // R1
        else $error("slot overflow flags not set");
    a_osc_stop: assert property (ovf_evt |=> !r.run && key_osc_en_o == '0 // R2
                                 && ref_osc_en_o == '0)
        else $error("oscillators still enabled after overflow");
    a_flag_w1_noop: assert property (wr_en && avs_address_i == A_CTRL && !r.slot_ovf // R3
                                     && !ovf_evt |=> !r.slot_ovf)
        else $error("slot overflow flag set by software");
    a_stop_zero: assert property (!r.start |=> r.calib == '0 && cf_cnt[0] == '0) // R4
        else $error("counters not zero while stopped");
    a_start_run: assert property (s_start_taken |=> s_running) // R6
        else $error("detection did not start");
    a_cf_ovf_set: assert property (|wrap |=> r.cf_ovf && r.irq_st[IRQ_CF]) // R7
        else $error("cf overflow not flagged");
    a_cal_ovf_set: assert property (r.start && r.run && cal_tk && r.calib == CNT_MAX // R8 R19
                                    |=> r.cal_ovf && r.calib == '0)
        else $error("calibration wrap not flagged");
    a_share_sel: assert property (r.run && r.share && done[0] |-> ovf_evt) // R9
        else $error("shared slot counter ignored");
    a_cal_div8: assert property (cal_tk && r.cal_sel == 2'h3 // R10
                                 |=> (!cal_tk || r.cal_sel != 2'h3)[*7])
        else $error("calibration clock faster than divide by 8");
    a_cal_hold: assert property (r.start && !r.run && !start_rise |=> $stable(r.calib)) // R12
        else $error("calibration counter moved after overflow");
    a_scan_load: assert property (r.auto_scan && slot_end[0] // R14
                                  |=> r.cap[0] == r.mem[0][r.scan_ptr])
        else $error("scan table not loaded at slot end");
    a_ctrl_msb_zero: assert property (r.ack && avs_read_i && avs_address_i == A_CTRL // R16
                                      |-> avs_readdata_o[31:7] == '0)
        else $error("unimplemented control bits read nonzero");

    // sticky flags drop only on a write to their own register
    a_slot_kept: assert property (r.slot_ovf && !ctrl_wr // R3
        |=> r.slot_ovf)
        else $error("slot flag dropped");
    a_cal_kept: assert property (r.cal_ovf && !ctrl_wr // R8
        |=> r.cal_ovf)
        else $error("calib flag dropped");
    // interrupt status is write-one-to-clear
    a_irq_kept: assert property (r.irq_st[IRQ_SLOT] && !(wr_en && avs_address_i == A_IRQ_ST) // R1
        |=> r.irq_st[IRQ_SLOT])
        else $error("slot irq status dropped");
    a_run_started: assert property (r.run // R4 R6
        |-> r.start)
        else $error("running while stopped");
    // a divided tick may never come early
    a_cal_div2: assert property (cal_tk && r.cal_sel == 2'h1 // R10
        |=> !cal_tk || r.cal_sel != 2'h1)
        else $error("calib clock above divide by 2");
    a_cal_div4: assert property (cal_tk && r.cal_sel == 2'h2 // R10
        |=> (!cal_tk || r.cal_sel != 2'h2)[*3])
        else $error("calib clock above divide by 4");
    a_slot_tick_gap: assert property (fsys4_tk // R18
        |=> (!fsys4_tk)[*3])
        else $error("slot tick above divide by 4");
    a_start_clears: assert property (start_rise // R6
        |=> r.calib == '0 && r.run)
        else $error("start did not clear calib");
endmodule : tks_top
